//--- bench/query_table_asserts.sv
// Checker for the query table Wishbone port.
// Assumes classic single cycles from one master; bound into the query_table module.
`timescale 1ns/1ns
module query_table_asserts
  import query_table_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic qry_r;
  logic byt_r;
  logic req;
  logic rd;
  logic win;
  assign req = wb_cyc_i && wb_stb_i;
  assign rd = wb_ack_o && !wb_we_i;
  assign win = (wb_adr_i & WIN_MASK) == WIN_BASE;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Mirror of the mode bits, updated on acked writes
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      qry_r <= 1'b0;
      byt_r <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == CMD_ADR)
        qry_r <= wb_dat_i[7:0] == CMD_QUERY;
      if (wb_adr_i == CTRL_ADR)
        byt_r <= wb_dat_i[0];
    end
  end
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_resp; req && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_no_ack; !req |=> !wb_ack_o; endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  property p_idle_zero; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data outside ack");
  property p_hi_zero; rd && win |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high lanes not zero");
  property p_array_zero; rd && win && !qry_r |-> wb_dat_o == 32'h00000000; endproperty
  a_array_zero: assert property (p_array_zero) else $error("window data in array mode");
  property p_qry_q;
    rd && qry_r && (byt_r ? wb_adr_i[11:3] == 9'h050 : wb_adr_i == 12'h240)
      |-> wb_dat_o[7:0] == 8'h51;
  endproperty
  a_qry_q: assert property (p_qry_q) else $error("first query byte wrong");
  property p_resv; rd && qry_r && !byt_r && wb_adr_i == 12'h2FC |-> wb_dat_o == 0; endproperty
  a_resv: assert property (p_resv) else $error("reserved offset not zero");
endmodule

bind query_table query_table_asserts query_table_asserts_inst (
  .clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
);

//--- bench/query_table_tb_top.sv
// Self-checking bench for the query table block.
// Assumes the host model drives the bus and the checker is bound in.
`timescale 1ns/1ns
module query_table_tb_top
  import query_table_pkg::*;
  ;
  // Arbitrary identifier value
  localparam logic [7:0] ID_LO = 8'h3C;
  localparam logic [7:0] ID_HI = 8'h00;
  localparam logic [7:0] BUF_EXP = 8'h06;
  localparam logic [7:0] MW = 8'h01;
  localparam logic [7:0] MB = 8'h01;
  // Expected query bytes for offsets 10H up to 3FH
  localparam logic [383:0] TAB = {24'h515259, ID_LO, ID_HI, 88'h3100000000002755275503,
    BUF_EXP, 16'hDADF, MW, MB, 88'h04041502000500011F0000,
    128'h0150524931300F000000010300505000};
  logic clk_sys;
  logic rst_b;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o, rdat;
  int err_count = 0;
  int check_count = 0;
  int cyc_count = 0;
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  query_table #(.PRI_ID_LO(ID_LO), .PRI_ID_HI(ID_HI), .TYP_BUF_EXP(BUF_EXP),
    .MAX_WRITE_MULT(MW), .MAX_BUF_MULT(MB)) query_table_inst (
    .clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  wb_host_model wb_host_model_inst (.clk_sys, .wb_dat_o, .wb_ack_o, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i);
  task automatic chk(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
    wb_host_model_inst.xfer(1'b0, a, 4'hF, 32'h00000000, rdat);
    chk(rdat, exp);
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s, input logic [31:0] d);
    wb_host_model_inst.xfer(1'b1, a, s, d, rdat);
  endtask
  function automatic logic [DAT_W-1:0] qexp(input int o);
    return (o < 'h10 || o > 'h3F) ? 32'h00000000 : {24'h000000, TAB[('h3F - o) * 8 +: 8]};
  endfunction
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 5000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(CTRL_ADR, 32'h00000000);
    rd(CMD_ADR, 32'h000000FF);
    rd(STATUS_ADR, 32'h00000000);
    rd(WIN_BASE + 12'h040, 32'h00000000);
    wr(CMD_ADR, 4'hE, 32'h00000098);
    rd(STATUS_ADR, 32'h00000000);
    $display("test reset and array mode done");
    wr(CMD_ADR, 4'hF, 32'h00000098);
    rd(STATUS_ADR, 32'h00000001);
    rd(CMD_ADR, 32'h00000098);
    for (int i = 0; i < 32; i++)
      rd(WIN_BASE + 12'(4 * i), qexp(i));
    for (int i = 32; i < 128; i++)
      rd(WIN_BASE + 12'(4 * i), qexp(i));
    $display("test word query done");
    wr(CTRL_ADR, 4'hF, 32'h00000001);
    rd(STATUS_ADR, 32'h00000003);
    for (int i = 0; i < 128; i++)
      rd(WIN_BASE + 12'(4 * i), qexp(i / 2));
    wr(STATUS_ADR, 4'hF, 32'h00000000);
    rd(STATUS_ADR, 32'h00000003);
    rd(12'h010, 32'h00000000);
    $display("test byte query done");
    wr(CMD_ADR, 4'hF, 32'h000000FF);
    rd(STATUS_ADR, 32'h00000002);
    rd(WIN_BASE + 12'h040, 32'h00000000);
    $display("test leave query done");
    final_report();
  end
endmodule

//--- bench/wb_host_model.sv
// Classic Wishbone master standing in for the host processor.
// Assumes the slave acks each request; the bench timeout covers a hang.
`timescale 1ns/1ns
module wb_host_model
  import query_table_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [ADR_W-1:0] wb_adr_i,
  output logic [SEL_W-1:0] wb_sel_i,
  output logic [DAT_W-1:0] wb_dat_i
);
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
  end
  // Request stands until ack is sampled; released address and data lines show inverted values
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
    input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
endmodule

//--- hw/query_table.sv
// Query database of a byte/word-wide flash part, reached over classic Wishbone.
// Assumes a single clock, synchronous inputs and a well-behaved Wishbone master.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns

// Functional notes
// - Query offsets 10H-12H return ASCII Q, R, Y.
// - Offsets 13H,14H return the primary command set identifier, low byte first.
// - Offsets 15H,16H return extended table location 31H,00H.
// - Alternate command set and table address bytes 17H-1AH read zero.
// - Supply limits at 1BH-1EH: 27H, 55H, 27H, 55H in tenths of volts.
// - Offset 1FH returns 3H, typical single write timeout exponent.
// - Offset 20H returns typical full buffer write timeout exponent.
// - Offset 21H returns DAH, typical block erase timeout.
// - Offset 22H returns DFH, typical chip erase timeout.
// - Offsets 23H-26H hold max timeout multipliers; erase entries are 04H.
// - Offsets 28H,29H return 02H,00H, byte and word width supported.
// - Offsets 2AH,2BH return 05H,00H, a 32-byte write buffer.
// - Offset 2CH returns 01H, one uniform erase region.
// - Offsets 2DH,2EH return 1FH,00H, thirty-two blocks.
// - Offsets 2FH,30H return 00H,01H, 64 kilobyte blocks.
// - Extended table: P, R, I at 31H-33H, versions 31H and 30H.
// - Offsets 36H-39H return 0FH,00H,00H,00H optional feature flags.
// - Offset 3AH returns 01H, write allowed during erase suspend.
// - Offsets 3BH,3CH return 03H,00H, lock and valid flags active.
// - Offsets 3DH,3EH return 50H, optimum supply voltages.
// - Offset 3FH is reserved and carries no information.
// - Query bytes sit on the low lane; word mode high lane is 00H.
// - In byte mode the lowest offset address bit is ignored.
// - Unassigned or reserved query locations read zero.
module query_table
  import query_table_pkg::*;
#(
  // Arbitrary neutral identifier value
  parameter logic [7:0] PRI_ID_LO = 8'h5A,
  // Arbitrary neutral identifier value
  parameter logic [7:0] PRI_ID_HI = 8'h00,
  parameter logic [7:0] TYP_BUF_EXP = 8'h06,
  parameter logic [7:0] MAX_WRITE_MULT = 8'h01,
  parameter logic [7:0] MAX_BUF_MULT = 8'h01
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    mode_type mode;
    logic byte_mode;
    logic [7:0] last_cmd;
    logic ack;
    logic [DAT_W-1:0] dat;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // Fixed query contents indexed by word offset
  function automatic logic [7:0] query_rom(input logic [OFS_W-1:0] ofs);
    logic [7:0] val;
    val = BYTE_ZERO;
    case (ofs)
      OFS_QRY_Q:
      begin
        val = VAL_ASCII_Q;
      end
      OFS_QRY_R:
      begin
        val = VAL_ASCII_R;
      end
      OFS_QRY_Y:
      begin
        val = VAL_ASCII_Y;
      end
      OFS_PRI_ID_LO:
      begin
        val = PRI_ID_LO;
      end
      OFS_PRI_ID_HI:
      begin
        val = PRI_ID_HI;
      end
      OFS_PRI_EXT_LO:
      begin
        val = VAL_PRI_EXT_LO;
      end
      OFS_PRI_EXT_HI:
      begin
        val = BYTE_ZERO;
      end
      OFS_VCC_MIN:
      begin
        val = VAL_VCC_MIN;
      end
      OFS_VCC_MAX:
      begin
        val = VAL_VCC_MAX;
      end
      OFS_VPP_MIN:
      begin
        val = VAL_VPP_MIN;
      end
      OFS_VPP_MAX:
      begin
        val = VAL_VPP_MAX;
      end
      OFS_TYP_WRITE:
      begin
        val = VAL_TYP_WRITE;
      end
      OFS_TYP_BUF:
      begin
        val = TYP_BUF_EXP;
      end
      OFS_TYP_BLK_ERASE:
      begin
        val = VAL_TYP_BLK_ERASE;
      end
      OFS_TYP_CHIP_ERASE:
      begin
        val = VAL_TYP_CHIP_ERASE;
      end
      OFS_MAX_WRITE:
      begin
        val = MAX_WRITE_MULT;
      end
      OFS_MAX_BUF:
      begin
        val = MAX_BUF_MULT;
      end
      OFS_MAX_BLK_ERASE:
      begin
        val = VAL_MAX_ERASE_MULT;
      end
      OFS_MAX_CHIP_ERASE:
      begin
        val = VAL_MAX_ERASE_MULT;
      end
      OFS_DEV_SIZE:
      begin
        val = VAL_DEV_SIZE;
      end
      OFS_IF_LO:
      begin
        val = VAL_IF_LO;
      end
      OFS_BUF_LO:
      begin
        val = VAL_BUF_LO;
      end
      OFS_REGIONS:
      begin
        val = VAL_REGIONS;
      end
      OFS_BLOCKS_LO:
      begin
        val = VAL_BLOCKS_LO;
      end
      OFS_BLK_SIZE_HI:
      begin
        val = VAL_BLK_SIZE_HI;
      end
      OFS_EXT_P:
      begin
        val = VAL_ASCII_P;
      end
      OFS_EXT_R:
      begin
        val = VAL_ASCII_R;
      end
      OFS_EXT_I:
      begin
        val = VAL_ASCII_I;
      end
      OFS_VER_MAJOR:
      begin
        val = VAL_VER_MAJOR;
      end
      OFS_VER_MINOR:
      begin
        val = VAL_VER_MINOR;
      end
      OFS_FEATURES:
      begin
        val = VAL_FEATURES;
      end
      OFS_SUSPEND_FN:
      begin
        val = VAL_SUSPEND_FN;
      end
      OFS_BLK_FLAG_MASK_LO:
      begin
        val = VAL_BLK_FLAG_MASK_LO
          & ((8'h01 << BLOCK_LOCK_FLAG_BIT) | (8'h01 << BLOCK_VALID_FLAG_BIT));
      end
      OFS_VCC_OPT:
      begin
        val = VAL_OPT_VOLT;
      end
      OFS_VPP_OPT:
      begin
        val = VAL_OPT_VOLT;
      end
      default:
      begin
        val = BYTE_ZERO;
      end
    endcase
    return val;
  endfunction

  // Maps a window index to a word offset, honouring the width select
  function automatic logic [OFS_W-1:0] window_offset(
    input logic [IDX_W-1:0] idx,
    input logic byte_mode
  );
    logic [OFS_W-1:0] ofs;
    ofs = idx;
    if (byte_mode)
    begin
      ofs = idx >> 1;
    end
    return ofs;
  endfunction

  // Full-word register address match
  function automatic logic reg_hit(
    input logic [ADR_W-1:0] adr,
    input logic [ADR_W-1:0] reg_adr
  );
    return adr == reg_adr;
  endfunction

  // Read mode selected by a command byte; any other byte returns to array reads
  function automatic mode_type mode_after_cmd(input logic [7:0] cmd);
    mode_type mode;
    mode = MODE_ARRAY;
    case (cmd)
      CMD_QUERY:
      begin
        mode = MODE_QUERY;
      end
      default:
      begin
        mode = MODE_ARRAY;
      end
    endcase
    return mode;
  endfunction

  // Status word: query mode flag and width select
  function automatic logic [DAT_W-1:0] status_word(
    input mode_type mode,
    input logic byte_mode
  );
    logic [DAT_W-1:0] word;
    word = '0;
    word[STATUS_QUERY_BIT] = mode == MODE_QUERY;
    word[STATUS_BYTE_MODE_BIT] = byte_mode;
    return word;
  endfunction

  logic req;
  logic in_window;
  logic [IDX_W-1:0] win_idx;
  logic [OFS_W-1:0] win_ofs;
  logic [7:0] win_byte;

  always_comb
  begin
    req = wb_cyc_i && wb_stb_i && !state_r.ack;
    in_window = (wb_adr_i & WIN_MASK) == WIN_BASE;
    win_idx = IDX_W'((wb_adr_i - WIN_BASE) >> WORD_SHIFT);
    win_ofs = window_offset(win_idx, state_r.byte_mode);
    win_byte = BYTE_ZERO;
    if (state_r.mode == MODE_QUERY && win_ofs <= OFS_LAST)
    begin
      win_byte = query_rom(win_ofs);
    end

    state_nxt = state_r;
    state_nxt.ack = req;
    state_nxt.dat = '0;
    if (req)
    begin
      if (wb_we_i)
      begin
        if (reg_hit(wb_adr_i, CTRL_ADR) && wb_sel_i[LANE0_BIT])
        begin
          state_nxt.byte_mode = wb_dat_i[CTRL_BYTE_MODE_BIT];
        end
        else if (reg_hit(wb_adr_i, CMD_ADR) && wb_sel_i[LANE0_BIT])
        begin
          state_nxt.last_cmd = wb_dat_i[7:0];
          state_nxt.mode = mode_after_cmd(wb_dat_i[7:0]);
        end
      end
      else
      begin
        case (1'b1)
          reg_hit(wb_adr_i, CTRL_ADR):
          begin
            state_nxt.dat[CTRL_BYTE_MODE_BIT] = state_r.byte_mode;
          end
          reg_hit(wb_adr_i, CMD_ADR):
          begin
            state_nxt.dat[7:0] = state_r.last_cmd;
          end
          reg_hit(wb_adr_i, STATUS_ADR):
          begin
            state_nxt.dat = status_word(state_r.mode, state_r.byte_mode);
          end
          // Low lane only; word mode high lane stays 00H
          in_window:
          begin
            state_nxt.dat[7:0] = win_byte;
          end
          default:
          begin
            state_nxt.dat = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r.mode <= MODE_ARRAY;
      state_r.byte_mode <= RST_BYTE_MODE;
      state_r.last_cmd <= RST_LAST_CMD;
      state_r.ack <= 1'b0;
      state_r.dat <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign wb_ack_o = state_r.ack;
  assign wb_dat_o = state_r.dat;

endmodule

//--- hw/query_table_pkg.sv
// Constants for the flash query database block: register map, command codes,
// query offsets and the fixed query contents.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package query_table_pkg;

  // Bus geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int WORD_SHIFT = 2;

  // Register map (byte addresses)
  localparam logic [ADR_W-1:0] CTRL_ADR = 12'h000;
  localparam logic [ADR_W-1:0] CMD_ADR = 12'h004;
  localparam logic [ADR_W-1:0] STATUS_ADR = 12'h008;
  localparam logic [ADR_W-1:0] WIN_BASE = 12'h200;
  localparam logic [ADR_W-1:0] WIN_MASK = 12'hE00;

  // Register fields
  localparam int CTRL_BYTE_MODE_BIT = 0;
  localparam int STATUS_QUERY_BIT = 0;
  localparam int STATUS_BYTE_MODE_BIT = 1;
  localparam int LANE0_BIT = 0;

  // Reset values
  localparam logic RST_BYTE_MODE = 1'b0;
  localparam logic [7:0] RST_LAST_CMD = 8'hFF;

  // Command codes
  localparam logic [7:0] CMD_QUERY = 8'h98;

  // Window and query offsets
  localparam int IDX_W = 7;
  localparam int OFS_W = 7;
  localparam logic [OFS_W-1:0] OFS_LAST = 7'h3F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam logic [OFS_W-1:0] OFS_QRY_Q = 7'h10;
  localparam logic [OFS_W-1:0] OFS_QRY_R = 7'h11;
  localparam logic [OFS_W-1:0] OFS_QRY_Y = 7'h12;
  localparam logic [OFS_W-1:0] OFS_PRI_ID_LO = 7'h13;
  localparam logic [OFS_W-1:0] OFS_PRI_ID_HI = 7'h14;
  localparam logic [OFS_W-1:0] OFS_PRI_EXT_LO = 7'h15;
  localparam logic [OFS_W-1:0] OFS_PRI_EXT_HI = 7'h16;
  localparam logic [OFS_W-1:0] OFS_VCC_MIN = 7'h1B;
  localparam logic [OFS_W-1:0] OFS_VCC_MAX = 7'h1C;
  localparam logic [OFS_W-1:0] OFS_VPP_MIN = 7'h1D;
  localparam logic [OFS_W-1:0] OFS_VPP_MAX = 7'h1E;
  localparam logic [OFS_W-1:0] OFS_TYP_WRITE = 7'h1F;
  localparam logic [OFS_W-1:0] OFS_TYP_BUF = 7'h20;
  localparam logic [OFS_W-1:0] OFS_TYP_BLK_ERASE = 7'h21;
  localparam logic [OFS_W-1:0] OFS_TYP_CHIP_ERASE = 7'h22;
  localparam logic [OFS_W-1:0] OFS_MAX_WRITE = 7'h23;
  localparam logic [OFS_W-1:0] OFS_MAX_BUF = 7'h24;
  localparam logic [OFS_W-1:0] OFS_MAX_BLK_ERASE = 7'h25;
  localparam logic [OFS_W-1:0] OFS_MAX_CHIP_ERASE = 7'h26;
  localparam logic [OFS_W-1:0] OFS_DEV_SIZE = 7'h27;
  localparam logic [OFS_W-1:0] OFS_IF_LO = 7'h28;
  localparam logic [OFS_W-1:0] OFS_BUF_LO = 7'h2A;
  localparam logic [OFS_W-1:0] OFS_REGIONS = 7'h2C;
  localparam logic [OFS_W-1:0] OFS_BLOCKS_LO = 7'h2D;
  localparam logic [OFS_W-1:0] OFS_BLK_SIZE_HI = 7'h30;
  localparam logic [OFS_W-1:0] OFS_EXT_P = 7'h31;
  localparam logic [OFS_W-1:0] OFS_EXT_R = 7'h32;
  localparam logic [OFS_W-1:0] OFS_EXT_I = 7'h33;
  localparam logic [OFS_W-1:0] OFS_VER_MAJOR = 7'h34;
  localparam logic [OFS_W-1:0] OFS_VER_MINOR = 7'h35;
  localparam logic [OFS_W-1:0] OFS_FEATURES = 7'h36;
  localparam logic [OFS_W-1:0] OFS_SUSPEND_FN = 7'h3A;
  localparam logic [OFS_W-1:0] OFS_BLK_FLAG_MASK_LO = 7'h3B;
  localparam logic [OFS_W-1:0] OFS_VCC_OPT = 7'h3D;
  localparam logic [OFS_W-1:0] OFS_VPP_OPT = 7'h3E;

  // Query contents
  localparam logic [7:0] VAL_ASCII_Q = 8'h51;
  localparam logic [7:0] VAL_ASCII_R = 8'h52;
  localparam logic [7:0] VAL_ASCII_Y = 8'h59;
  localparam logic [7:0] VAL_PRI_EXT_LO = 8'h31;
  localparam logic [7:0] VAL_VCC_MIN = 8'h27;
  localparam logic [7:0] VAL_VCC_MAX = 8'h55;
  localparam logic [7:0] VAL_VPP_MIN = 8'h27;
  localparam logic [7:0] VAL_VPP_MAX = 8'h55;
  localparam logic [7:0] VAL_TYP_WRITE = 8'h03;
  localparam logic [7:0] VAL_TYP_BLK_ERASE = 8'hDA;
  localparam logic [7:0] VAL_TYP_CHIP_ERASE = 8'hDF;
  localparam logic [7:0] VAL_MAX_ERASE_MULT = 8'h04;
  localparam logic [7:0] VAL_DEV_SIZE = 8'h15;
  localparam logic [7:0] VAL_IF_LO = 8'h02;
  localparam logic [7:0] VAL_BUF_LO = 8'h05;
  localparam logic [7:0] VAL_REGIONS = 8'h01;
  localparam logic [7:0] VAL_BLOCKS_LO = 8'h1F;
  localparam logic [7:0] VAL_BLK_SIZE_HI = 8'h01;
  localparam logic [7:0] VAL_ASCII_P = 8'h50;
  localparam logic [7:0] VAL_ASCII_I = 8'h49;
  localparam logic [7:0] VAL_VER_MAJOR = 8'h31;
  localparam logic [7:0] VAL_VER_MINOR = 8'h30;
  localparam logic [7:0] VAL_FEATURES = 8'h0F;
  localparam logic [7:0] VAL_SUSPEND_FN = 8'h01;
  localparam logic [7:0] VAL_BLK_FLAG_MASK_LO = 8'h03;
  localparam logic [7:0] VAL_OPT_VOLT = 8'h50;

  // Bit positions inside the block status mask byte
  localparam int BLOCK_LOCK_FLAG_BIT = 0;
  localparam int BLOCK_VALID_FLAG_BIT = 1;

  // Read mode of the device
  typedef enum logic [0:0] {
    MODE_ARRAY = 1'b0,
    MODE_QUERY = 1'b1
  } mode_type;

endpackage
